// file: rtl/cca_top.v
`timescale 1ns/100ps
`include "cca_defs.vh"

module cca_top (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Shared counter link
  input wire [15:0] counter_value,
  input wire count_tick,
  // Module io lines
  input wire [5:0] module_io_line_in,
  output reg [5:0] module_io_line_out,
  output reg [5:0] module_io_line_oe_n,
  // Interrupt request
  output reg irq
);

  // Limitations
  // The counter itself and its timebase live outside this block
  // Counter reads and watchdog use are not handled here
  // Only the low eight bits of each written word are kept
  // Capture takes three clocks from pin edge to register
  // Compare events act on the edge of the tick that carries them

  // ----------------------------------------
  // Mode codes
  // ----------------------------------------
  localparam M_IDLE = 3'd0;
  localparam M_CAP = 3'd1;
  localparam M_TMR = 3'd2;
  localparam M_HSO = 3'd3;
  localparam M_FRQ = 3'd4;
  localparam M_P8 = 3'd5;
  localparam M_P16 = 3'd6;
  localparam M_POFF = 3'd7;

  // Mode table, bit order wide, comparator, rise, fall, match, toggle, pulse, irq
  //   Capture: rise or fall set, match, toggle and pulse clear
  //   Software timer: comparator and match set, toggle and pulse clear
  //   High-speed output: comparator, match and toggle set, pulse clear
  //   Frequency output: comparator, toggle and pulse set, match clear
  //   8-bit pulse: comparator and pulse set, wide select clear
  //   16-bit pulse: comparator, pulse and wide select set
  //   Pulse off: pulse set with comparator clear, line held low
  // Any other mix decodes to idle and leaves the line alone
  // Capture with any compare bit set is idle too, so a half-written
  // mode never captures and drives at once
  // The irq enable bit takes no part in the decode

  // Mode decode from one mode register
  // Returns one of the mode codes above
  // Pure decode of the stored bits, no state
  function [2:0] cca_mode;
    input [7:0] m;
    reg cap;
    begin
      cap = m[`CCA_B_RISE] | m[`CCA_B_FALL];
      cca_mode = M_IDLE;
      if (cap && !m[`CCA_B_MAT] && !m[`CCA_B_TOG] && !m[`CCA_B_PWM])
        cca_mode = M_CAP;
      else if (cap)
        cca_mode = M_IDLE;
      else if (m[`CCA_B_MAT] && !m[`CCA_B_PWM])
        cca_mode = !m[`CCA_B_ECOM] ? M_IDLE : (m[`CCA_B_TOG] ? M_HSO : M_TMR);
      else if (!m[`CCA_B_MAT] && m[`CCA_B_TOG] && m[`CCA_B_PWM])
        cca_mode = m[`CCA_B_ECOM] ? M_FRQ : M_POFF;
      else if (!m[`CCA_B_MAT] && !m[`CCA_B_TOG] && m[`CCA_B_PWM])
        cca_mode = !m[`CCA_B_ECOM] ? M_POFF : (m[`CCA_B_WIDE] ? M_P16 : M_P8);
    end
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [7:0] mode_reg [0:5];
  reg [7:0] cmp_lo [0:5];
  reg [7:0] cmp_hi [0:5];
  reg [5:0] capture_compare_flag;
  reg global_irq_enable;
  reg array_irq_enable;
  reg [5:0] hso_prev;
  reg [5:0] sync_a;
  reg [5:0] sync_b;
  reg [5:0] sync_c;

  // Storage notes
  // Compare low and high bytes double as the capture register
  // Frequency mode rewrites the low byte on every match
  // 8-bit pulse mode reloads the low byte at each low-byte rollover
  // Flags are only ever set by the engines; software clears them
  // hso_prev remembers last cycle's mode to find entry into toggling
  // sync_a and sync_b form the two-stage synchroniser
  // sync_c is the previous synchronised sample for edge finding
  // Control bits gate the shared interrupt line only

  // ----------------------------------------
  // Per-module decode
  // ----------------------------------------
  reg [2:0] cur_mode [0:5];
  reg [5:0] match16;
  reg [5:0] match_lo;
  reg [5:0] cap_evt;
  reg [5:0] irq_en_vec;
  reg [5:0] drive_vec;
  wire low_ovf;
  wire full_ovf;
  integer k;

  // Event qualifiers
  // A match only counts on a tick, so a stalled counter
  // cannot toggle a line or set a flag twice
  // Low overflow is a tick that lands on a low byte of zero
  // Full overflow is a tick that lands on zero in all 16 bits
  // Capture edges look at synchronised samples only

  assign low_ovf = count_tick & (counter_value[7:0] == 8'h00);
  assign full_ovf = count_tick & (counter_value == 16'h0000);

  // Matches, edges and mode per module
  // cur_mode feeds both the engines and the capture qualifier
  // drive_vec marks modules that own their line
  always @*
  begin
    for (k = 0; k < `CCA_NMOD; k = k + 1)
    begin
      cur_mode[k] = cca_mode(mode_reg[k]);
      match16[k] = count_tick & (counter_value == {cmp_hi[k], cmp_lo[k]});
      match_lo[k] = count_tick & (counter_value[7:0] == cmp_lo[k]);
      cap_evt[k] = (cur_mode[k] == M_CAP) &
        ((mode_reg[k][`CCA_B_RISE] & sync_b[k] & ~sync_c[k]) |
         (mode_reg[k][`CCA_B_FALL] & ~sync_b[k] & sync_c[k]));
      irq_en_vec[k] = mode_reg[k][`CCA_B_IRQEN];
      drive_vec[k] = mode_reg[k][`CCA_B_TOG] | mode_reg[k][`CCA_B_PWM];
    end
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  reg [31:0] rd_val;
  reg rd_hit;
  wire [2:0] sel_mod;
  wire mod_space;
  wire bus_write;

  // Bus decode notes
  // Module n lives at base n times 0x10
  // Offset 0 mode, 4 compare low, 8 compare high, C unmapped
  // Flags at 0x60, write one to clear
  // Control at 0x64, bit 0 global and bit 1 array enable
  // Anything else answers with an error and reads zero
  // Writes land only in the access cycle with pready high

  assign sel_mod = paddr[6:4];
  assign mod_space = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0) && (sel_mod < 3'd6)
    && (paddr[3:2] != 2'h3);
  assign bus_write = psel & penable & pready & pwrite;

  // Read data and address check
  // rd_hit low means the address is unmapped
  // The same check serves reads and writes
  always @*
  begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (mod_space)
    begin
      case (paddr[3:2])
        `CCA_REG_MODE: rd_val = {24'h000000, mode_reg[sel_mod]};
        `CCA_REG_CPL: rd_val = {24'h000000, cmp_lo[sel_mod]};
        `CCA_REG_CPH: rd_val = {24'h000000, cmp_hi[sel_mod]};
        default: rd_hit = 1'b0;
      endcase
    end
    else if (paddr == `CCA_ADDR_FLAG)
      rd_val = {26'h0000000, capture_compare_flag};
    else if (paddr == `CCA_ADDR_CTRL)
      rd_val = {30'h00000000, array_irq_enable, global_irq_enable};
    else
      rd_hit = 1'b0;
  end

  // Bus answer, one cycle after setup
  // pready rises in the cycle after setup and lasts one clock
  // There are no wait states
  // Read data are latched at setup and held until the next setup
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      if (psel && !penable)
        prdata <= (pwrite || !rd_hit) ? 32'h0000_0000 : rd_val;
    end
  end

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  // The pins are asynchronous to pclk
  // Two flops settle any metastable sample
  // A third flop holds the prior sample for edge finding
  // A level must stand two clocks to be seen reliably
  // Reset clears all three so an idle low pin gives no edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
      sync_c <= 6'h00;
    end
    else
    begin
      sync_a <= module_io_line_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // ----------------------------------------
  // Module engines and register writes
  // ----------------------------------------
  integer i;

  // Engine notes
  // One process owns every per-module register so the bus and
  // the engines never drive the same flop from two places
  // Order inside the process matters
  //   Flag clear by software comes first
  //   Engine events come next and win over that clear
  //   Bus writes to module registers come last and win over the engines
  // High-speed output forces the line high in its first cycle
  // and toggles on matches from the next cycle on
  // Frequency output toggles and steps the low byte on each low match
  // 8-bit pulse goes low at rollover unless the high byte is zero
  // 16-bit pulse goes low at overflow unless the compare is zero
  // The output enable follows the toggle and pulse bits
  // Unused modes hold the line where it was

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (i = 0; i < `CCA_NMOD; i = i + 1)
      begin
        mode_reg[i] <= `CCA_RST_BYTE;
        cmp_lo[i] <= `CCA_RST_BYTE;
        cmp_hi[i] <= `CCA_RST_BYTE;
      end
      capture_compare_flag <= 6'h00;
      global_irq_enable <= 1'b0;
      array_irq_enable <= 1'b0;
      hso_prev <= 6'h00;
      module_io_line_out <= 6'h00;
      module_io_line_oe_n <= 6'h3F;
      irq <= 1'b0;
    end
    else
    begin
      // Software clear first so a same-cycle event still sets
      if (bus_write && paddr == `CCA_ADDR_FLAG)
        capture_compare_flag <= capture_compare_flag & ~pwdata[5:0];
      if (bus_write && paddr == `CCA_ADDR_CTRL)
      begin
        global_irq_enable <= pwdata[`CCA_B_GIE];
        array_irq_enable <= pwdata[`CCA_B_AIE];
      end
      for (i = 0; i < `CCA_NMOD; i = i + 1)
      begin
        hso_prev[i] <= (cur_mode[i] == M_HSO);
        module_io_line_oe_n[i] <= ~drive_vec[i];
        case (cur_mode[i])
          // Copy the counter on a chosen edge
          M_CAP:
          begin
            if (cap_evt[i])
            begin
              cmp_lo[i] <= counter_value[7:0];
              cmp_hi[i] <= counter_value[15:8];
              capture_compare_flag[i] <= 1'b1;
            end
          end
          // Flag on a full match
          M_TMR:
          begin
            if (match16[i])
              capture_compare_flag[i] <= 1'b1;
          end
          // Toggle on a full match
          M_HSO:
          begin
            if (!hso_prev[i])
              module_io_line_out[i] <= 1'b1;
            else if (match16[i])
              module_io_line_out[i] <= ~module_io_line_out[i];
            if (match16[i])
              capture_compare_flag[i] <= 1'b1;
          end
          // Square wave from low-byte matches
          M_FRQ:
          begin
            if (match_lo[i])
            begin
              module_io_line_out[i] <= ~module_io_line_out[i];
              cmp_lo[i] <= cmp_lo[i] + cmp_hi[i];
            end
          end
          // Eight-bit pulse width
          M_P8:
          begin
            if (low_ovf)
            begin
              cmp_lo[i] <= cmp_hi[i];
              module_io_line_out[i] <= (cmp_hi[i] == 8'h00);
            end
            else if (match_lo[i])
              module_io_line_out[i] <= 1'b1;
          end
          // Sixteen-bit pulse width
          M_P16:
          begin
            if (full_ovf)
              module_io_line_out[i] <= ({cmp_hi[i], cmp_lo[i]} == 16'h0000);
            else if (match16[i])
              module_io_line_out[i] <= 1'b1;
            if (match16[i])
              capture_compare_flag[i] <= 1'b1;
          end
          // Pulse mode with comparator off
          M_POFF:
            module_io_line_out[i] <= 1'b0;
          default:
            module_io_line_out[i] <= module_io_line_out[i];
        endcase
        // Software writes to this module
        if (bus_write && mod_space && sel_mod == i[2:0])
        begin
          case (paddr[3:2])
            `CCA_REG_MODE: mode_reg[i] <= pwdata[7:0];
            `CCA_REG_CPL:
            begin
              cmp_lo[i] <= pwdata[7:0];
              mode_reg[i][`CCA_B_ECOM] <= 1'b0;
            end
            `CCA_REG_CPH:
            begin
              cmp_hi[i] <= pwdata[7:0];
              mode_reg[i][`CCA_B_ECOM] <= 1'b1;
            end
            default: mode_reg[i] <= mode_reg[i];
          endcase
        end
      end
      // Three-way interrupt gate
      // Registered, so the line rises one clock after the flag
      // and falls one clock after a clear or an enable drop
      // Flags with their enable bit clear never reach the line
      irq <= global_irq_enable & array_irq_enable &
        (|(capture_compare_flag & irq_en_vec));
    end
  end

endmodule // cca_top

// file: rtl/cca_defs.vh
`ifndef CCA_DEFS_VH
`define CCA_DEFS_VH

// ----------------------------------------
// Register map (register indices within a module, byte addresses)
// ----------------------------------------
`define CCA_NMOD 6
`define CCA_REG_MODE 2'h0
`define CCA_REG_CPL 2'h1
`define CCA_REG_CPH 2'h2
`define CCA_ADDR_FLAG 12'h060
`define CCA_ADDR_CTRL 12'h064

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define CCA_B_WIDE 7
`define CCA_B_ECOM 6
`define CCA_B_RISE 5
`define CCA_B_FALL 4
`define CCA_B_MAT 3
`define CCA_B_TOG 2
`define CCA_B_PWM 1
`define CCA_B_IRQEN 0

// ----------------------------------------
// Control register fields and resets
// ----------------------------------------
`define CCA_B_GIE 0
`define CCA_B_AIE 1
`define CCA_RST_BYTE 8'h00

`endif

// file: dv/cca_checker.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port-level checker
// ----------------------------------------
module cca_checker (
  // Clock, reset and bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  // Counter and lines
  input wire [15:0] counter_value,
  input wire count_tick,
  input wire [5:0] module_io_line_in,
  input wire [5:0] module_io_line_out,
  input wire irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel & penable & pready & pwrite;
  reg [7:0] m0;
  reg [15:0] cp;
  reg [1:0] ct;
  wire pw8 = m0[7:1] == 7'h21;
  wire hso = m0[6:1] == 6'h26;
  wire frq = m0[6:1] == 6'h23;
  // Shadow of module 0 mode, compare and the control bits
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      m0 <= 8'h00;
      cp <= 16'h0000;
      ct <= 2'h0;
    end
    else if (wr && paddr == 12'h000)
      m0 <= pwdata[7:0];
    else if (wr && paddr == 12'h004)
    begin
      cp[7:0] <= pwdata[7:0];
      m0[6] <= 1'b0;
    end
    else if (wr && paddr == 12'h008)
    begin
      cp[15:8] <= pwdata[7:0];
      m0[6] <= 1'b1;
    end
    else if (wr && paddr == 12'h064)
      ct <= pwdata[1:0];
    else if (count_tick && pw8 && counter_value[7:0] == 8'h00)
      cp[7:0] <= cp[15:8];
    else if (count_tick && frq && counter_value[7:0] == cp[7:0])
      cp[7:0] <= cp[7:0] + cp[15:8];
  AST_CAPTURE_IRQ: assert property
    ($rose(module_io_line_in[0]) && m0[5:0] == 6'h21 && ct == 2'h3 |-> ##[3:6] irq)
    else $error("capture edge raised no interrupt");
  AST_TIMER_IRQ: assert property
    (count_tick && m0[6:0] == 7'h49 && ct == 2'h3 && counter_value == cp |-> ##[1:2] irq)
    else $error("timer match raised no interrupt");
  AST_IRQ_FALL: assert property
    ($fell(irq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("interrupt dropped without a write");
  AST_IRQ_GATE: assert property
    ((ct != 2'h3) [*2] |-> !irq)
    else $error("interrupt with array enables off");
  AST_HSO_TOGGLE: assert property
    (count_tick && hso && $past(m0, 2) == m0 && counter_value == cp
      |=> module_io_line_out[0] != $past(module_io_line_out[0]))
    else $error("output did not toggle on match");
  AST_HSO_ENTER: assert property
    (wr && !count_tick && paddr == 12'h000 && pwdata[6:1] == 6'h26 && !hso
      ##1 !count_tick [*3] |-> module_io_line_out[0])
    else $error("output not one on entry");
  AST_PWM_HIGH: assert property
    (count_tick && pw8 && counter_value[7:0] != 8'h00 && counter_value[7:0] == cp[7:0]
      |=> module_io_line_out[0])
    else $error("pwm output not high on match");
  AST_PWM_WRAP: assert property
    (count_tick && pw8 && counter_value[7:0] == 8'h00
      |=> module_io_line_out[0] == ($past(cp[15:8]) == 8'h00))
    else $error("pwm output wrong at rollover");
  AST_PWM_OFF: assert property
    ((m0[6:1] == 6'h01) [*3] |-> !module_io_line_out[0])
    else $error("pwm output high with comparator off");
endmodule // cca_checker

bind cca_top cca_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .counter_value(counter_value), .count_tick(count_tick), .irq(irq),
  .module_io_line_in(module_io_line_in), .module_io_line_out(module_io_line_out));

// file: dv/cca_pin_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Outside source on the io lines
// ----------------------------------------
module cca_pin_model (
  // Clock
  pclk,
  // Requested level and block drive
  level_req,
  drive_n,
  drive,
  // Resolved lines
  pin
);
  input wire pclk;
  input wire [5:0] level_req;
  input wire [5:0] drive_n;
  input wire [5:0] drive;
  output wire [5:0] pin;
  reg [5:0] src = 6'h00;
  reg [1:0] age = 2'h3;
  // Level moves only after two held clocks
  always @(posedge pclk)
    if (level_req != src && age >= 2'h2)
    begin
      src <= level_req;
      age <= 2'h0;
    end
    else if (age != 2'h3)
      age <= age + 2'h1;
  // Block drive wins where enabled
  assign pin = (~drive_n & drive) | (drive_n & src);
endmodule // cca_pin_model

// file: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg count_tick = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [15:0] counter_value = 16'h0000;
  reg [5:0] lvl = 6'h00;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  wire [5:0] pin, out, oe_n;
  reg [31:0] rdat, rerr;
  integer failures = 0, n_tests = 0, hi, tg;
  cca_top u_cca_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counter_value(counter_value), .count_tick(count_tick),
    .module_io_line_in(pin), .module_io_line_out(out), .module_io_line_oe_n(oe_n), .irq(irq));
  cca_pin_model u_cca_pin_model (.pclk(pclk), .level_req(lvl), .drive_n(oe_n), .drive(out),
    .pin(pin));
  // ----------------------------------------
  // Clock, checks and bus tasks
  // ----------------------------------------
  initial
    forever #5 pclk = ~pclk;
  task close_out;
    begin
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20)
      begin
        k = k + 1;
        @(posedge pclk);
      end
      if (k == 20)
      begin
        failures = failures + 1;
        close_out;
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      chk(rdat, e);
    end
  endtask
  // Ticks the counter from s; counts high samples and toggles of line 0
  task sweep(input [15:0] s, input integer n);
    integer i;
    reg last;
    begin
      hi = 0;
      tg = 0;
      last = out[0];
      for (i = 0; i < n + 2; i = i + 1)
      begin
        @(posedge pclk);
        count_tick <= (i < n);
        counter_value <= s + i;
        // Settled output of the tick driven one iteration earlier
        @(negedge pclk);
        if (i >= 1 && i <= n)
        begin
          hi = hi + out[0];
          tg = tg + (out[0] != last);
          last = out[0];
        end
      end
    end
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h0FC, 32'h0);
    chk(rerr, 32'h1);
    $display("test reset done");
    xfer(1'b1, 12'h064, 32'h3);
    xfer(1'b1, 12'h000, 32'h49);
    xfer(1'b1, 12'h004, 32'h34);
    rd(12'h000, 32'h09);
    xfer(1'b1, 12'h008, 32'h12);
    rd(12'h000, 32'h49);
    sweep(16'h1234, 1);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h1);
    rd(12'h060, 32'h1);
    xfer(1'b1, 12'h064, 32'h1);
    repeat (3) @(posedge pclk);
    chk(irq, 32'h0);
    xfer(1'b1, 12'h064, 32'h3);
    repeat (3) @(posedge pclk);
    chk(irq, 32'h1);
    xfer(1'b1, 12'h060, 32'h1);
    rd(12'h060, 32'h0);
    $display("test timer done");
    xfer(1'b1, 12'h000, 32'h21);
    counter_value <= 16'hABCD;
    lvl <= 6'h01;
    repeat (8) @(posedge pclk);
    rd(12'h004, 32'hCD);
    rd(12'h008, 32'hAB);
    rd(12'h060, 32'h1);
    xfer(1'b1, 12'h000, 32'h10);
    counter_value <= 16'h0F1E;
    lvl <= 6'h00;
    repeat (8) @(posedge pclk);
    rd(12'h004, 32'h1E);
    $display("test capture done");
    xfer(1'b1, 12'h004, 32'h10);
    xfer(1'b1, 12'h008, 32'h0);
    xfer(1'b1, 12'h000, 32'h4C);
    repeat (3) @(posedge pclk);
    chk(out[0], 32'h1);
    sweep(16'h000E, 4);
    chk(tg, 32'h1);
    xfer(1'b1, 12'h004, 32'h0);
    xfer(1'b1, 12'h008, 32'h10);
    xfer(1'b1, 12'h000, 32'h46);
    sweep(16'h0000, 256);
    chk(tg, 32'h10);
    xfer(1'b1, 12'h008, 32'h0);
    sweep(16'h0000, 512);
    chk(tg, 32'h2);
    $display("test outputs done");
    xfer(1'b1, 12'h004, 32'h0);
    xfer(1'b1, 12'h008, 32'hC0);
    xfer(1'b1, 12'h000, 32'h42);
    sweep(16'h0000, 512);
    chk(hi, 32'h80);
    xfer(1'b1, 12'h008, 32'h0);
    sweep(16'h0000, 256);
    chk(hi, 32'h100);
    xfer(1'b1, 12'h000, 32'h02);
    repeat (4) @(posedge pclk);
    chk(out[0], 32'h0);
    xfer(1'b1, 12'h004, 32'hF0);
    xfer(1'b1, 12'h008, 32'hFF);
    xfer(1'b1, 12'h060, 32'h1);
    xfer(1'b1, 12'h000, 32'hC3);
    sweep(16'hFFE0, 64);
    chk(hi, 32'h10);
    rd(12'h060, 32'h1);
    xfer(1'b1, 12'h010, 32'h4C);
    repeat (3) @(posedge pclk);
    chk(oe_n, 32'h3C);
    $display("test pwm done");
    close_out;
  end
endmodule // testbench
